/* design/sas_pkg.sv */
// constants for the servo amplifier setup and fault supervisor
package sas_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned US_CYCLES       = CLK_HZ / 1_000_000;
  localparam int unsigned RECOVER_WAIT_MS = 2;
  localparam int unsigned RECOVER_CYCLES  = RECOVER_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned PHASE_LOCK_MS   = 100;
  localparam int unsigned PHASE_LOCK_CYC  = PHASE_LOCK_MS * (CLK_HZ / 1000);
  localparam logic [15:0] SAMPLE_US_RST   = 16'h03e8;
  localparam int unsigned NUM_AXES        = 4;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FAULT  = 8'h0c;
  localparam logic [7:0] OFS_CFG0   = 8'h10;
  localparam logic [7:0] OFS_LIM0   = 8'h20;

  // ---------------------------------------------------------------
  // command word and opcodes
  // ---------------------------------------------------------------
  localparam int unsigned CMD_AXIS_LSB = 4;
  localparam logic [3:0] OP_SERVO_ON   = 4'h1;
  localparam logic [3:0] OP_DRIVE_OFF  = 4'h2;
  localparam logic [3:0] OP_PHASE_LOCK = 4'h3;
  localparam logic [3:0] OP_PHASE_FIND = 4'h4;

  // ---------------------------------------------------------------
  // axis configuration fields and codes
  // ---------------------------------------------------------------
  localparam int unsigned CFG_GAIN_LSB = 0;
  localparam int unsigned CFG_LOOP_LSB = 2;
  localparam int unsigned CFG_TYPE_LSB = 5;
  localparam logic [1:0] GAIN_LOW      = 2'h0;
  localparam logic [1:0] GAIN_MID      = 2'h1;
  localparam logic [1:0] GAIN_HIGH     = 2'h2;
  localparam logic [15:0] GAIN_LOW_MA  = 16'h0190;
  localparam logic [15:0] GAIN_MID_MA  = 16'h0320;
  localparam logic [15:0] GAIN_HIGH_MA = 16'h0640;
  localparam logic [15:0] HIGH_GAIN_LIMIT_MV = 16'h1388;
  localparam logic [1:0] MOTOR_BRUSHLESS = 2'h0;
  localparam logic [1:0] MOTOR_BRUSHED   = 2'h1;
  localparam logic [1:0] MOTOR_EXTERNAL  = 2'h2;

  // ---------------------------------------------------------------
  // fault query selectors and bits
  // ---------------------------------------------------------------
  localparam logic [1:0] FQ_SUPPLY  = 2'h0;
  localparam logic [1:0] FQ_CONT    = 2'h2;
  localparam logic [1:0] FQ_CUTOFF  = 2'h3;
  localparam int unsigned FB_UNDER  = 0;
  localparam int unsigned FB_OVER   = 1;
  localparam int unsigned FB_OCUR   = 2;
  localparam int unsigned FB_OTEMP  = 3;
  localparam int unsigned ST_REFUSED = 8;
  localparam int unsigned ST_CUTOFF  = 9;

  typedef enum logic [1:0] {CS_IDLE, CS_LOCK, CS_FIND, CS_READY} sas_setup_e;
endpackage : sas_pkg

/* design/sas_supervisor.sv */
// servo amplifier setup and fault supervisor with wishbone registers
`timescale 1ns/1ps
`default_nettype none

// Function
// R01: gain codes 0,1,2 give 0.4,0.8,1.6 A/V
// R02: gain changes only while axis drive-off
// R03: gain code 2 clamps command limit 5V
// R04: host sets drive-off, gain, then loop gain
// R05: host picks loop gain 0..4 by supply
// R06: brushless needs phase setup before servo enable
// R07: phase lock energises phase to lock rotor
// R08: host issues no phase commands on brushed
// R09: external motor type drops setup precondition
// R10: cutoff disables amp, drive-off, flag, handler
// R11: cutoff recovery: drive-off, 2 ms, enable
// R12: fault query selectors 0,2,3, eight bits
// R13: selector 0 reports supply, current, temperature
// R14: selector 2 reports continuous current exceeded
// R15: fault query read has no side effects
// R16: amp error jumps thread zero to handler
// R17: under 18V disables, recovers automatically
// R18: power-up under-voltage triggers fault handler
// R19: over 94V disables, re-enables below 90V
// R20: over-voltage neither latches nor calls handler
// R21: sample period in us, default 1000
// R22: host keeps eight samples per magnetic cycle
// R23: supply and cutoff inputs synchronised single bits
module sas_supervisor #(
  parameter int unsigned RECOVER_CYC = sas_pkg::RECOVER_CYCLES,
  parameter int unsigned LOCK_CYC    = sas_pkg::PHASE_LOCK_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // amplifier condition pins
  input  wire logic        emergencyCutoffInput,
  input  wire logic        supplyBelow18,
  input  wire logic        supplyAbove94,
  input  wire logic        supplyBelow90,
  input  wire logic        overCurrent,
  input  wire logic        overTemp,
  input  wire logic [3:0]  overContinuous,
  input  wire logic [3:0]  phaseFindDone,
  // program sequencer
  input  wire logic        threadZeroRunning,
  input  wire logic        ampFaultHandlerPresent,
  output logic             ampFaultHandlerJump,
  // power stage
  output logic      [3:0]  ampEnable,
  output logic      [3:0]  phaseLockDrive,
  output logic      [3:0]  phaseFindReq,
  output logic      [7:0]  ampGainSelect,
  output logic      [11:0] currentLoopGain,
  output logic      [63:0] gainMilliAmpPerVolt,
  output logic      [63:0] continuousLimit,
  output logic             sampleTick
);
  localparam int unsigned NA = sas_pkg::NUM_AXES;

  function automatic logic [15:0] gain_ma(input logic [1:0] code);
    case (code)
      sas_pkg::GAIN_LOW:  gain_ma = sas_pkg::GAIN_LOW_MA;
      sas_pkg::GAIN_MID:  gain_ma = sas_pkg::GAIN_MID_MA;
      default:            gain_ma = sas_pkg::GAIN_HIGH_MA;
    endcase
  endfunction : gain_ma

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [13:0] pinMeta_r;
  logic [13:0] pinSync_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end else begin
      pinMeta_r <= {phaseFindDone, overContinuous, overTemp, overCurrent,
                    supplyBelow90, supplyAbove94, supplyBelow18, emergencyCutoffInput};
      pinSync_r <= pinMeta_r;
    end
  end
  logic       cutoffIn;
  logic       underVolt;
  logic       above94;
  logic       below90;
  logic       ocur;
  logic       otemp;
  logic [3:0] overCont;
  logic [3:0] findDone;
  // R23: synchronised condition bits
  assign {findDone, overCont, otemp, ocur, below90, above94, underVolt, cutoffIn} = pinSync_r;

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  logic ack_r;
  logic wbReq;
  logic wbWr;
  assign wbReq    = wb_cyc_i & wb_stb_i;
  assign wbWr     = wbReq & wb_we_i & ack_r & wb_sel_i[0];
  assign wb_ack_o = ack_r;
  always_ff @(posedge clk) begin
    if (rst) ack_r <= 1'b0;
    else     ack_r <= wbReq & ~ack_r;
  end

  logic       cmdWr;
  logic [3:0] cmdOp;
  logic [1:0] cmdAxis;
  assign cmdWr   = wbWr && wb_adr_i == sas_pkg::OFS_CMD;
  assign cmdOp   = wb_dat_i[3:0];
  assign cmdAxis = wb_dat_i[sas_pkg::CMD_AXIS_LSB +: 2];

  // ---------------------------------------------------------------
  // supply supervision
  // ---------------------------------------------------------------
  logic overVolt_r;
  // R19: hysteresis between 94V and 90V
  always_ff @(posedge clk) begin
    if (rst)          overVolt_r <= 1'b0;
    else if (above94) overVolt_r <= 1'b1;
    else if (below90) overVolt_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // emergency cutoff latch and recovery wait
  // ---------------------------------------------------------------
  logic        cutoffLatch_r;
  logic        recoverArmed_r;
  logic [31:0] recoverCnt_r;
  logic        recoverDone;
  logic        recoverOk;
  logic        cutoffClear;
  assign recoverDone = recoverArmed_r && recoverCnt_r == '0;
  assign recoverOk   = recoverDone & ~cutoffIn;
  assign cutoffClear = cmdWr && cmdOp == sas_pkg::OP_SERVO_ON && cutoffLatch_r && recoverOk;
  // R10: latch cutoff
  always_ff @(posedge clk) begin
    if (rst)              cutoffLatch_r <= 1'b0;
    else if (cutoffIn)    cutoffLatch_r <= 1'b1;
    else if (cutoffClear) cutoffLatch_r <= 1'b0;
  end
  // R11: drive-off starts the 2 ms wait
  always_ff @(posedge clk) begin
    if (rst) begin
      recoverArmed_r <= 1'b0;
      recoverCnt_r   <= '0;
    end else if (!cutoffLatch_r || cutoffIn) begin
      recoverArmed_r <= 1'b0;
      recoverCnt_r   <= '0;
    end else if (cmdWr && cmdOp == sas_pkg::OP_DRIVE_OFF) begin
      recoverArmed_r <= 1'b1;
      recoverCnt_r   <= 32'(RECOVER_CYC);
    end else if (recoverCnt_r != '0) begin
      recoverCnt_r <= recoverCnt_r - 32'd1;
    end
  end

  // ---------------------------------------------------------------
  // per-axis configuration, setup and enable
  // ---------------------------------------------------------------
  logic [NA-1:0] servoOn_r;
  logic [NA-1:0] ready;
  logic [NA-1:0] refuse;
  logic [1:0]    motorType [NA];
  genvar a;
  generate
    for (a = 0; a < NA; a++) begin : g_axis
      logic [1:0]         gain_r;
      logic [2:0]         loop_r;
      logic [1:0]         type_r;
      logic [15:0]        lim_r;
      logic [15:0]        limOut_r;
      logic [31:0]        lockCnt_r;
      sas_pkg::sas_setup_e setup_r;
      logic sel;
      logic cfgWr;
      logic limWr;
      logic cfgBad;
      logic onReq;
      logic onOk;
      logic lockReq;
      logic findReq;
      logic setupOk;
      assign sel   = cmdWr && cmdAxis == 2'(a);
      assign cfgWr = wbWr && wb_adr_i == sas_pkg::OFS_CFG0 + 8'(4 * a);
      assign limWr = wbWr && wb_adr_i == sas_pkg::OFS_LIM0 + 8'(4 * a);
      // R02: configuration only while drive-off
      assign cfgBad = cfgWr && (servoOn_r[a] ||
                      wb_dat_i[sas_pkg::CFG_GAIN_LSB +: 2] > sas_pkg::GAIN_HIGH);
      assign setupOk = type_r != sas_pkg::MOTOR_BRUSHLESS;
      assign onReq   = sel && cmdOp == sas_pkg::OP_SERVO_ON;
      // R06: brushless needs finished setup
      // R09: other motor types skip setup
      assign onOk    = (setup_r == sas_pkg::CS_READY || setupOk) &&
                       (!cutoffLatch_r || recoverOk);
      assign lockReq = sel && cmdOp == sas_pkg::OP_PHASE_LOCK;
      assign findReq = sel && cmdOp == sas_pkg::OP_PHASE_FIND;
      assign refuse[a] = cfgBad || (onReq && !onOk) ||
                         ((lockReq || findReq) && (setupOk || cutoffLatch_r));
      assign ready[a]     = setup_r == sas_pkg::CS_READY;
      assign motorType[a] = type_r;

      always_ff @(posedge clk) begin
        if (rst) begin
          gain_r <= sas_pkg::GAIN_MID;
          loop_r <= '0;
          type_r <= sas_pkg::MOTOR_BRUSHLESS;
        end else if (cfgWr && !cfgBad) begin
          gain_r <= wb_dat_i[sas_pkg::CFG_GAIN_LSB +: 2];
          loop_r <= wb_dat_i[sas_pkg::CFG_LOOP_LSB +: 3];
          type_r <= wb_dat_i[sas_pkg::CFG_TYPE_LSB +: 2];
        end
      end

      always_ff @(posedge clk) begin
        if (rst)        lim_r <= '0;
        else if (limWr) lim_r <= wb_dat_i[15:0];
      end
      // R03: high gain clamps the command limit
      always_ff @(posedge clk) begin
        if (rst) limOut_r <= '0;
        else if (gain_r == sas_pkg::GAIN_HIGH && lim_r > sas_pkg::HIGH_GAIN_LIMIT_MV)
          limOut_r <= sas_pkg::HIGH_GAIN_LIMIT_MV;
        else limOut_r <= lim_r;
      end

      // R10: cutoff forces drive-off
      always_ff @(posedge clk) begin
        if (rst)                                     servoOn_r[a] <= 1'b0;
        else if (cutoffIn)                           servoOn_r[a] <= 1'b0;
        else if (sel && cmdOp == sas_pkg::OP_DRIVE_OFF) servoOn_r[a] <= 1'b0;
        else if (onReq && onOk)                      servoOn_r[a] <= 1'b1;
      end

      // R07: phase lock holds a phase energised
      always_ff @(posedge clk) begin
        if (rst || cutoffIn || setupOk) begin
          setup_r   <= sas_pkg::CS_IDLE;
          lockCnt_r <= '0;
        end else begin
          case (setup_r)
            sas_pkg::CS_IDLE, sas_pkg::CS_READY: begin
              // refused while cutoff is latched
              if (lockReq && !cutoffLatch_r) begin
                setup_r   <= sas_pkg::CS_LOCK;
                lockCnt_r <= 32'(LOCK_CYC);
              end else if (findReq && !cutoffLatch_r) begin
                setup_r <= sas_pkg::CS_FIND;
              end
            end
            sas_pkg::CS_LOCK: begin
              if (lockCnt_r <= 32'd1) setup_r <= sas_pkg::CS_READY;
              lockCnt_r <= lockCnt_r - 32'd1;
            end
            sas_pkg::CS_FIND: begin
              if (findDone[a]) setup_r <= sas_pkg::CS_READY;
            end
            default: setup_r <= sas_pkg::CS_IDLE;
          endcase
        end
      end

      // R17: supply faults gate enable
      // R20: over-voltage gates only while present
      assign ampEnable[a] = (servoOn_r[a] || setup_r == sas_pkg::CS_LOCK) && !cutoffIn &&
                            !cutoffLatch_r && !underVolt && !overVolt_r;
      assign phaseLockDrive[a] = setup_r == sas_pkg::CS_LOCK;
      assign phaseFindReq[a]   = setup_r == sas_pkg::CS_FIND;
      // R01: gain code to transconductance
      assign gainMilliAmpPerVolt[16*a +: 16] = gain_ma(gain_r);
      assign ampGainSelect[2*a +: 2]         = gain_r;
      assign currentLoopGain[3*a +: 3]       = loop_r;
      assign continuousLimit[16*a +: 16]     = limOut_r;
    end
  endgenerate

  // ---------------------------------------------------------------
  // refused command flag, fault query, sample period
  // ---------------------------------------------------------------
  logic        refused_r;
  logic [1:0]  faultSel_r;
  logic [15:0] period_r;
  always_ff @(posedge clk) begin
    if (rst) refused_r <= 1'b0;
    else if (|refuse) refused_r <= 1'b1;
    else if (wbWr && wb_adr_i == sas_pkg::OFS_STATUS && wb_dat_i[sas_pkg::ST_REFUSED])
      refused_r <= 1'b0;
  end
  always_ff @(posedge clk) begin
    if (rst) faultSel_r <= sas_pkg::FQ_SUPPLY;
    else if (wbWr && wb_adr_i == sas_pkg::OFS_FAULT) faultSel_r <= wb_dat_i[1:0];
  end
  // R21: programmable sample period
  always_ff @(posedge clk) begin
    if (rst) period_r <= sas_pkg::SAMPLE_US_RST;
    else if (wbWr && wb_adr_i == sas_pkg::OFS_PERIOD) period_r <= wb_dat_i[15:0];
  end

  // R12: eight-bit fault word per selector
  logic [7:0] faultWord;
  always_comb begin
    faultWord = '0;
    case (faultSel_r)
      // R13: supply, current, temperature
      sas_pkg::FQ_SUPPLY: begin
        faultWord[sas_pkg::FB_UNDER] = underVolt;
        faultWord[sas_pkg::FB_OVER]  = overVolt_r;
        faultWord[sas_pkg::FB_OCUR]  = ocur;
        faultWord[sas_pkg::FB_OTEMP] = otemp;
      end
      // R14: continuous current exceeded
      sas_pkg::FQ_CONT:   faultWord[NA-1:0] = overCont;
      sas_pkg::FQ_CUTOFF: faultWord[0] = cutoffLatch_r;
      default:            faultWord = '0;
    endcase
  end

  // R15: reads only sample state
  always_ff @(posedge clk) begin
    if (rst) wb_dat_o <= '0;
    else if (wbReq && !ack_r && !wb_we_i) begin
      wb_dat_o <= '0;
      case (wb_adr_i)
        sas_pkg::OFS_PERIOD: wb_dat_o[15:0] <= period_r;
        sas_pkg::OFS_STATUS: begin
          wb_dat_o[NA-1:0]         <= servoOn_r;
          wb_dat_o[2*NA-1:NA]      <= ready;
          wb_dat_o[sas_pkg::ST_REFUSED] <= refused_r;
          wb_dat_o[sas_pkg::ST_CUTOFF]  <= cutoffLatch_r;
        end
        sas_pkg::OFS_FAULT:  wb_dat_o[7:0] <= faultWord;
        default: begin
          for (int i = 0; i < NA; i++) begin
            if (wb_adr_i == sas_pkg::OFS_CFG0 + 8'(4 * i))
              wb_dat_o[6:0] <= {motorType[i], currentLoopGain[3*i +: 3], ampGainSelect[2*i +: 2]};
            if (wb_adr_i == sas_pkg::OFS_LIM0 + 8'(4 * i))
              wb_dat_o[15:0] <= continuousLimit[16*i +: 16];
          end
        end
      endcase
    end
  end

  logic [6:0]  usCnt_r;
  logic [15:0] smpCnt_r;
  logic        usTick;
  assign usTick = usCnt_r == 7'(sas_pkg::US_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (rst || usTick) usCnt_r <= '0;
    else               usCnt_r <= usCnt_r + 7'd1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      smpCnt_r   <= '0;
      sampleTick <= 1'b0;
    end else begin
      sampleTick <= 1'b0;
      if (usTick) begin
        if (smpCnt_r + 16'd1 >= period_r) begin
          smpCnt_r   <= '0;
          sampleTick <= 1'b1;
        end else smpCnt_r <= smpCnt_r + 16'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // fault handler dispatch
  // ---------------------------------------------------------------
  logic [3:0] errPrev_r;
  logic [3:0] errNow;
  // R20: over-voltage left out of handler events
  assign errNow = {otemp, ocur, underVolt, cutoffIn};
  // R16: error edge jumps thread zero
  // R18: reset value lets early under-voltage fire
  always_ff @(posedge clk) begin
    if (rst) begin
      errPrev_r           <= '0;
      ampFaultHandlerJump <= 1'b0;
    end else begin
      errPrev_r           <= errNow;
      ampFaultHandlerJump <= |(errNow & ~errPrev_r) && threadZeroRunning &&
                             ampFaultHandlerPresent;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_high_gain_clamp: assert property ( // R03
    continuousLimit[15:0] > sas_pkg::HIGH_GAIN_LIMIT_MV |-> ampGainSelect[1:0] != sas_pkg::GAIN_HIGH
      || $past(ampGainSelect[1:0]) != sas_pkg::GAIN_HIGH) else $error("limit over 5V at high gain");
  a_gain_map: assert property ( // R01
    ampGainSelect[1:0] == sas_pkg::GAIN_LOW |-> gainMilliAmpPerVolt[15:0] == sas_pkg::GAIN_LOW_MA)
    else $error("gain map wrong");
  a_gain_when_off: assert property ( // R02
    servoOn_r[0] && $stable(servoOn_r[0]) |=> $stable(ampGainSelect[1:0])) else $error("gain moved while on");
  a_setup_before_on: assert property ( // R06
    $rose(servoOn_r[0]) && motorType[0] == sas_pkg::MOTOR_BRUSHLESS |-> ready[0])
    else $error("enable without setup");
  a_lock_drive: assert property ( // R07
    $rose(phaseLockDrive[0]) |-> ampEnable[0] || cutoffIn || underVolt || overVolt_r)
    else $error("lock without drive");
  a_cutoff_off: assert property ( // R10
    cutoffIn |-> ampEnable == '0 ##1 servoOn_r == '0 && cutoffLatch_r) else $error("cutoff ignored");
  a_cutoff_stays: assert property ( // R11
    cutoffLatch_r && !cutoffClear |=> cutoffLatch_r) else $error("cutoff left early");
  a_under_volt: assert property ( // R17
    underVolt |-> ampEnable == '0) else $error("enabled under voltage");
  a_over_volt: assert property ( // R19
    above94 |=> overVolt_r ##0 ampEnable == '0) else $error("enabled over voltage");
  a_ov_release: assert property ( // R20
    overVolt_r && below90 && !above94 |=> !overVolt_r) else $error("over voltage latched");
  a_handler_jump: assert property ( // R16
    $rose(cutoffIn) && threadZeroRunning && ampFaultHandlerPresent |=> ampFaultHandlerJump)
    else $error("handler not called");
  a_cutoff_query: assert property ( // R12
    faultSel_r == sas_pkg::FQ_CUTOFF |-> faultWord[0] == cutoffLatch_r) else $error("query wrong");

  c_servo_on:   cover property ($rose(servoOn_r[0]));
  c_recover:    cover property (cutoffClear);
  c_lock_done:  cover property ($fell(phaseLockDrive[0]) && ready[0]);
  c_handler:    cover property (ampFaultHandlerJump);
endmodule : sas_supervisor

`default_nettype wire

/* tb/sas_power_stage_model.sv */
// power stage model answering phase find requests
`timescale 1ns/1ps
`default_nettype none
module sas_power_stage_model (
  // clock
  input  wire logic       clk,
  // phase find handshake
  input  wire logic [3:0] phaseFindReq,
  output var  logic [3:0] phaseFindDone
);
  int cnt [4];
  // --------------------------------------
  // phase find response, slower per axis
  // --------------------------------------
  // phase find completes
  always_ff @(posedge clk) begin
    for (int a = 0; a < 4; a++) begin
      cnt[a]           <= phaseFindReq[a] ? cnt[a] + 1 : 0;
      phaseFindDone[a] <= phaseFindReq[a] && cnt[a] >= 4 + 6 * a;
    end
  end
endmodule : sas_power_stage_model
`default_nettype wire

/* tb/sas_supervisor_tb_top.sv */
// self-checking bench for the amplifier supervisor
`timescale 1ns/1ps
`default_nettype none
module sas_supervisor_tb_top;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
  logic        cut = 0, u18 = 0, o94 = 0, b90 = 1, ack, jump;
  logic        oc = 0, ot = 0, tz = 1, tick;
  logic [7:0]  adr = 0, gSel;
  logic [3:0]  oCont = 0, enb, lockDrv, findReq, findDone;
  logic [31:0] dat = 0, datO, q;
  logic [63:0] gainMa, lim;
  logic [15:0] gTab [3] = '{sas_pkg::GAIN_LOW_MA, sas_pkg::GAIN_MID_MA, sas_pkg::GAIN_HIGH_MA};
  int          failures = 0, nTests = 0, nJump = 0, nTick = 0, n0 = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (jump === 1'b1) nJump <= nJump + 1;
  always @(posedge clk) if (tick === 1'b1) nTick <= nTick + 1;
  sas_supervisor #(.RECOVER_CYC(20), .LOCK_CYC(10)) uut (.clk(clk), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .emergencyCutoffInput(cut),
    .supplyBelow18(u18), .supplyAbove94(o94), .supplyBelow90(b90), .overCurrent(oc),
    .overTemp(ot), .overContinuous(oCont), .phaseFindDone(findDone),
    .threadZeroRunning(tz), .ampFaultHandlerPresent(1'b1), .ampFaultHandlerJump(jump),
    .ampEnable(enb), .phaseLockDrive(lockDrv), .phaseFindReq(findReq), .ampGainSelect(gSel),
    .currentLoopGain(), .gainMilliAmpPerVolt(gainMa), .continuousLimit(lim),
    .sampleTick(tick));
  sas_power_stage_model ps (.clk(clk), .phaseFindReq(findReq), .phaseFindDone(findDone));
  // ------------------
  // bus and check tasks
  // ------------------
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = datO;
    if (n >= 40) failures++;
    cyc <= 0;
    stb <= 0;
  endtask : xfer
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input string s, input logic [31:0] e);
    xfer(a, 0, 0);
    chk(s, e, q);
  endtask : rd
  task automatic fq(input logic [1:0] s, input logic [31:0] e);
    xfer(8'h0c, 1, {30'h0, s});
    rd(8'h0c, "fault", e);
  endtask : fq
  task automatic cmd(input logic [3:0] op, input logic [1:0] ax);
    xfer(8'h00, 1, {26'h0, ax, op});
  endtask : cmd
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic en(input logic [3:0] e);
    chk("enable", {28'h0, e}, {28'h0, enb});
  endtask : en
  task automatic endTest(input string s);
    $display("test %s done", s);
  endtask : endTest
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // ------------------
  // tests
  // ------------------
  initial begin
    step(6);
    rst <= 0;
    rd(8'h04, "period", 32'd1000);
    rd(8'h08, "status", 32'h0);
    rd(8'h80, "unmapped", 32'h0);
    chk("gain", 32'd800, gainMa[15:0]);
    endTest("reset");
    foreach (gTab[i]) begin
      xfer(8'h10, 1, i);
      step(2);
      chk("gain", gTab[i], gainMa[15:0]);
    end
    xfer(8'h20, 1, 32'd8000);
    rd(8'h20, "limit", 32'd5000);
    chk("limit", 32'd5000, lim[15:0]);
    xfer(8'h10, 1, 32'h3);
    rd(8'h08, "status", 32'h100);
    // loop gain code from 0 to 2
    xfer(8'h10, 1, 32'h9);
    rd(8'h10, "cfg", 32'h9);
    rd(8'h20, "limit", 32'd8000);
    endTest("gain");
    xfer(8'h08, 1, 32'h100);
    cmd(sas_pkg::OP_SERVO_ON, 0);
    rd(8'h08, "status", 32'h100);
    xfer(8'h08, 1, 32'h100);
    cmd(sas_pkg::OP_PHASE_LOCK, 0);
    step(1);
    chk("lock", 32'h1, {28'h0, lockDrv});
    step(15);
    chk("lock", 32'h0, {28'h0, lockDrv});
    cmd(sas_pkg::OP_SERVO_ON, 0);
    step(2);
    en(4'h1);
    xfer(8'h10, 1, 32'h0);
    rd(8'h08, "status", 32'h111);
    chk("gain", 32'd800, gainMa[15:0]);
    xfer(8'h14, 1, 32'h41);
    // axis one gets no phase command
    cmd(sas_pkg::OP_SERVO_ON, 1);
    cmd(sas_pkg::OP_PHASE_FIND, 3);
    step(40);
    cmd(sas_pkg::OP_SERVO_ON, 3);
    step(2);
    en(4'hb);
    endTest("setup");
    u18 <= 1;
    step(5);
    en(4'h0);
    chk("jump", 32'h1, nJump);
    fq(sas_pkg::FQ_SUPPLY, 32'h1);
    rd(8'h0c, "fault", 32'h1);
    u18 <= 0;
    step(4);
    en(4'hb);
    o94 <= 1;
    b90 <= 0;
    step(4);
    en(4'h0);
    o94 <= 0;
    step(4);
    en(4'h0);
    fq(sas_pkg::FQ_SUPPLY, 32'h2);
    b90 <= 1;
    step(4);
    en(4'hb);
    chk("jump", 32'h1, nJump);
    oCont <= 4'h5;
    step(3);
    fq(sas_pkg::FQ_CONT, 32'h5);
    fq(2'h1, 32'h0);
    endTest("supply");
    cut <= 1;
    step(5);
    en(4'h0);
    chk("jump", 32'h2, nJump);
    fq(sas_pkg::FQ_CUTOFF, 32'h1);
    xfer(8'h08, 0, 0);
    chk("status", 32'h200, q & 32'h200);
    cut <= 0;
    step(3);
    cmd(sas_pkg::OP_SERVO_ON, 1);
    step(2);
    en(4'h0);
    cmd(sas_pkg::OP_DRIVE_OFF, 1);
    step(25);
    cmd(sas_pkg::OP_SERVO_ON, 1);
    step(2);
    en(4'h2);
    endTest("cutoff");
    // handler only while thread zero runs
    tz <= 0;
    oc <= 1;
    step(5);
    chk("jump", 32'h2, nJump);
    fq(sas_pkg::FQ_SUPPLY, 32'h4);
    tz <= 1;
    ot <= 1;
    step(5);
    chk("jump", 32'h3, nJump);
    fq(sas_pkg::FQ_SUPPLY, 32'hc);
    endTest("handler");
    xfer(8'h04, 1, 32'h1);
    step(200);
    n0 = nTick;
    step(1000);
    chk("ticks", 32'd10, nTick - n0);
    endTest("period");
    oc <= 0;
    ot <= 0;
    u18 <= 1;
    rst <= 1;
    step(6);
    rst <= 0;
    step(6);
    chk("jump", 32'h4, nJump);
    en(4'h0);
    chk("gain sel", 32'h55, {24'h0, gSel});
    rd(8'h04, "period", 32'd1000);
    rd(8'h08, "status", 32'h0);
    endTest("reset again");
    give_verdict();
  end
  initial begin
    step(5000);
    failures++;
    give_verdict();
  end
endmodule : sas_supervisor_tb_top
`default_nettype wire
